// >>> pkg/ppx_pkg.sv
// Constants and types for the per-port PHY, serial and MAC control registers
package ppx_pkg;

	// Register addresses on the plain port
	localparam int          ADDR_W         = 12;
	localparam logic [11:0] OFF_PHY_CTRL   = 12'h13e;
	localparam logic [11:0] OFF_IND_ADDR   = 12'h200;
	localparam logic [11:0] OFF_IND_DATA   = 12'h206;
	localparam logic [11:0] OFF_MAC_CTRL0  = 12'h300;
	localparam logic [11:0] OFF_MAC_CTRL1  = 12'h301;

	// Field positions
	localparam int BIT_JABBER    = 9;
	localparam int BIT_AUTOINC   = 23;
	localparam int BIT_DUPLEX    = 6;
	localparam int BIT_TX_FC     = 5;
	localparam int BIT_SPEED_100 = 4;
	localparam int BIT_RX_FC     = 3;
	localparam int BIT_SEL_10100 = 6;

	// Reset values
	localparam logic [15:0] RST_PHY_CTRL   = 16'h0300;
	localparam logic [20:0] RST_IND_ADDR   = 21'h1f0000;
	localparam logic [15:0] RST_IND_DATA   = 16'h0000;
	localparam logic [7:0]  RST_MAC_CTRL0  = 8'h50;
	localparam logic [7:0]  RST_MAC_CTRL1  = 8'h08;
	// Writable bits of the PHY control register and control byte 0
	localparam logic [15:0] WMASK_PHY_CTRL = 16'hf382;
	localparam logic [7:0]  WMASK_CTRL0    = 8'h7f;

	// Resolved link speed
	typedef enum logic [1:0] {
		PPX_SPD_10   = 2'h0,
		PPX_SPD_100  = 2'h1,
		PPX_SPD_1000 = 2'h2
	} ppx_speed_e;

	// Indirect address split
	typedef struct packed {
		logic [4:0] dev;
		logic       vendor;
		logic [6:0] mid;
		logic [7:0] offset;
	} ppx_ind_addr_s;

	// PHY status inputs
	typedef struct packed {
		logic is_1000;
		logic is_100;
		logic is_10;
		logic full_duplex;
		logic master;
	} ppx_phy_stat_s;

	// MAC port settings driven out
	typedef struct packed {
		logic       full_duplex;
		logic       tx_fc_en;
		logic       rx_fc_en;
		ppx_speed_e speed;
	} ppx_mac_cfg_s;

endpackage

// >>> rtl/ppx_regs.sv
// Per-port PHY control, indirect serial window and MAC control registers
`timescale 1ns/100ps
`default_nettype none

module ppx_regs
	import ppx_pkg::*;
#(
	parameter logic CTRL0_BIT7 = 1'b0
) (
	input  wire logic                clk,
	input  wire logic                srst,
	// Register port
	input  wire logic [ADDR_W-1:0]   addr,
	input  wire logic [31:0]         wr_data,
	input  wire logic                wr_en,
	input  wire logic                rd_en,
	output var  logic [31:0]         rd_data,
	// PHY side
	input  wire ppx_phy_stat_s       phy_stat,
	output var  logic                jabber_cnt_en,
	// Straps seen while reset is held
	input  wire logic                strap_flow_ctl,
	input  wire logic                strap_sel_10100,
	// Indirect serial register space
	output var  ppx_ind_addr_s       ind_addr,
	input  wire logic [15:0]         ind_rdata,
	output var  ppx_ind_addr_s       ind_acc_addr,
	output var  logic [15:0]         ind_wdata,
	output var  logic                ind_wr,
	output var  logic                ind_rd,
	// Parallel MAC port settings
	output var  ppx_mac_cfg_s        mac_cfg
);

	////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic [15:0]   phy_ctrl;
		logic          autoinc;
		ppx_ind_addr_s ind;
		logic [15:0]   ind_data;
		logic [7:0]    ctrl0;
		logic [7:0]    ctrl1;
		logic [31:0]   rd_data;
		ppx_ind_addr_s acc_addr;
		logic [15:0]   wdata;
		logic          wr;
		logic          rd;
		ppx_mac_cfg_s  cfg;
	} ppx_state_s;

	ppx_state_s st_r;
	ppx_state_s st_nxt;

	// Address hits
	logic hit_phy;
	logic hit_iaddr;
	logic hit_idata;
	logic hit_c0;
	logic hit_c1;

	assign hit_phy   = (addr == OFF_PHY_CTRL);
	assign hit_iaddr = (addr == OFF_IND_ADDR);
	assign hit_idata = (addr == OFF_IND_DATA);
	assign hit_c0    = (addr == OFF_MAC_CTRL0);
	assign hit_c1    = (addr == OFF_MAC_CTRL1);

	////////////////////////////////////////////////////////////////////
	// Read views

	// PHY control word with live status bits
	logic [15:0] phy_view;
	// Address register as software sees it
	logic [31:0] iaddr_view;
	// Control byte 0 with fixed top bit
	logic [7:0]  c0_view;

	always_comb begin
		phy_view = st_r.phy_ctrl & WMASK_PHY_CTRL;
		phy_view[6] = phy_stat.is_1000;
		phy_view[5] = phy_stat.is_100;
		phy_view[4] = phy_stat.is_10;
		phy_view[3] = phy_stat.full_duplex;
		phy_view[2] = phy_stat.master;
	end

	assign iaddr_view = {8'h00, st_r.autoinc, 2'h0, st_r.ind};

	assign c0_view = {CTRL0_BIT7, st_r.ctrl0[6:0]};

	////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		st_nxt = st_r;
		st_nxt.wr = 1'b0;
		st_nxt.rd = 1'b0;
		st_nxt.rd_data = 32'h00000000;

		// Read data only in the cycle after the strobe
		if (rd_en) begin
			if (hit_phy) begin
				st_nxt.rd_data = {16'h0000, phy_view};
			end else if (hit_iaddr) begin
				st_nxt.rd_data = iaddr_view;
			end else if (hit_idata) begin
				st_nxt.rd_data = {16'h0000, ind_rdata};
			end else if (hit_c0) begin
				st_nxt.rd_data = {24'h000000, c0_view};
			end else if (hit_c1) begin
				st_nxt.rd_data = {24'h000000, st_r.ctrl1};
			end else begin
				st_nxt.rd_data = 32'h00000000;
			end
		end

		// Indirect data read side effect
		if (rd_en && hit_idata) begin
			st_nxt.ind_data = ind_rdata;
			st_nxt.acc_addr = st_r.ind;
			st_nxt.rd       = 1'b1;
		end

		// Register writes
		if (wr_en) begin
			if (hit_phy) begin
				st_nxt.phy_ctrl = wr_data[15:0] & WMASK_PHY_CTRL;
			end
			if (hit_iaddr) begin
				st_nxt.ind     = wr_data[20:0];
				st_nxt.autoinc = wr_data[BIT_AUTOINC];
			end
			if (hit_idata) begin
				st_nxt.ind_data = wr_data[15:0];
				st_nxt.wdata    = wr_data[15:0];
				st_nxt.acc_addr = st_r.ind;
				st_nxt.wr       = 1'b1;
			end
			if (hit_c0) begin
				st_nxt.ctrl0 = wr_data[7:0] & WMASK_CTRL0;
			end
			if (hit_c1) begin
				st_nxt.ctrl1 = wr_data[7:0];
			end
		end

		if ((wr_en || rd_en) && hit_idata && st_r.autoinc) begin
			st_nxt.ind = ppx_ind_addr_s'(st_r.ind + 21'h000001);
		end

		// MAC settings follow the control bytes
		// duplex select
		st_nxt.cfg.full_duplex = st_nxt.ctrl0[BIT_DUPLEX];
		st_nxt.cfg.tx_fc_en = st_nxt.ctrl0[BIT_TX_FC];
		st_nxt.cfg.rx_fc_en = st_nxt.ctrl0[BIT_RX_FC];

		if (!st_nxt.ctrl1[BIT_SEL_10100]) begin
			st_nxt.cfg.speed = PPX_SPD_1000;
		end else if (st_nxt.ctrl0[BIT_SPEED_100]) begin
			st_nxt.cfg.speed = PPX_SPD_100;
		end else begin
			st_nxt.cfg.speed = PPX_SPD_10;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Registers

	// Straps are taken as long as reset is held
	always_ff @(posedge clk) begin
		if (srst) begin
			st_r          <= '0;
			st_r.phy_ctrl <= RST_PHY_CTRL;
			st_r.ind      <= RST_IND_ADDR;
			st_r.ind_data <= RST_IND_DATA;
			st_r.ctrl0    <= RST_MAC_CTRL0;
			st_r.ctrl0[BIT_TX_FC] <= strap_flow_ctl;
			st_r.ctrl0[BIT_RX_FC] <= strap_flow_ctl;
			st_r.ctrl1    <= RST_MAC_CTRL1;
			st_r.ctrl1[BIT_SEL_10100] <= strap_sel_10100;
			st_r.cfg.full_duplex <= RST_MAC_CTRL0[BIT_DUPLEX];
			st_r.cfg.tx_fc_en    <= strap_flow_ctl;
			st_r.cfg.rx_fc_en    <= strap_flow_ctl;
			st_r.cfg.speed <= strap_sel_10100 ? PPX_SPD_100 : PPX_SPD_1000;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs, all straight from the state

	assign rd_data       = st_r.rd_data;
	assign jabber_cnt_en = st_r.phy_ctrl[BIT_JABBER];
	assign ind_addr      = st_r.ind;
	assign ind_acc_addr  = st_r.acc_addr;
	assign ind_wdata     = st_r.wdata;
	assign ind_wr        = st_r.wr;
	assign ind_rd        = st_r.rd;
	assign mac_cfg       = st_r.cfg;

endmodule // ppx_regs

`default_nettype wire

// >>> bench/ppx_regs_monitor.sv
// Assertion checker for the port register slice
`timescale 1ns/100ps
`default_nettype none

module ppx_regs_monitor
	import ppx_pkg::*;
(
	input wire logic          clk,
	input wire logic          srst,
	input wire logic [11:0]   addr,
	input wire logic [31:0]   wr_data,
	input wire logic          wr_en,
	input wire logic          rd_en,
	input wire logic [31:0]   rd_data,
	input wire ppx_phy_stat_s phy_stat,
	input wire logic          jabber_cnt_en,
	input wire logic          strap_sel_10100,
	input wire ppx_ind_addr_s ind_addr,
	input wire logic [15:0]   ind_rdata,
	input wire ppx_ind_addr_s ind_acc_addr,
	input wire logic [15:0]   ind_wdata,
	input wire logic          ind_wr,
	input wire logic          ind_rd,
	input wire ppx_mac_cfg_s  mac_cfg
);
	logic ai_r;
	logic sel_r;
	logic s100_r;
	logic dacc;

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	////////////////////////////////////////
	// Shadows of the bits the outputs hang on
	assign dacc = (wr_en || rd_en) && addr == OFF_IND_DATA;
	always_ff @(posedge clk) begin
		if (srst) begin
			ai_r <= 1'b0;
			sel_r <= strap_sel_10100;
			s100_r <= 1'b1;
		end else if (wr_en) begin
			if (addr == OFF_IND_ADDR) ai_r <= wr_data[23];
			if (addr == OFF_MAC_CTRL1) sel_r <= wr_data[6];
			if (addr == OFF_MAC_CTRL0) s100_r <= wr_data[4];
		end
	end

	////////////////////////////////////////
	a_jabber_wr: assert property (wr_en && addr == OFF_PHY_CTRL
		|=> jabber_cnt_en == $past(wr_data[9])) else $error("jabber enable wrong");
	a_phy_status: assert property (rd_en && addr == OFF_PHY_CTRL
		|=> rd_data[6:2] == $past(phy_stat)) else $error("status bits wrong");
	a_ind_read: assert property (rd_en && addr == OFF_IND_DATA
		|=> ind_rd && rd_data == {16'h0, $past(ind_rdata)}
		##1 (!ind_rd || $past(rd_en && addr == OFF_IND_DATA))) else $error("bad read");
	a_ind_write: assert property (wr_en && addr == OFF_IND_DATA
		|=> ind_wr && ind_wdata == $past(wr_data[15:0])
		##1 (!ind_wr || $past(wr_en && addr == OFF_IND_DATA))) else $error("bad write");
	a_auto_inc: assert property (dacc
		|=> ind_addr == 21'($past(ind_addr) + ai_r)) else $error("address step wrong");
	a_access_addr: assert property (dacc
		|=> ind_acc_addr == $past(ind_addr)) else $error("access address wrong");
	a_mac_ctrl: assert property (wr_en && addr == OFF_MAC_CTRL0
		|=> mac_cfg[4:2] == {$past(wr_data[6]), $past(wr_data[5]), $past(wr_data[3])})
		else $error("duplex or flow control wrong");
	a_speed_sel: assert property (mac_cfg.speed ==
		(!sel_r ? PPX_SPD_1000 : (s100_r ? PPX_SPD_100 : PPX_SPD_10))) else $error("bad speed");

endmodule // ppx_regs_monitor

bind ppx_regs ppx_regs_monitor ppx_regs_monitor_inst (.clk, .srst, .addr, .wr_data, .wr_en,
	.rd_en, .rd_data, .phy_stat, .jabber_cnt_en, .strap_sel_10100, .ind_addr, .ind_rdata,
	.ind_acc_addr, .ind_wdata, .ind_wr, .ind_rd, .mac_cfg);

`default_nettype wire

// >>> bench/ppx_regs_bench.sv
// Self-checking bench for the port register slice
`timescale 1ns/100ps
`default_nettype none

module ppx_regs_bench
	import ppx_pkg::*;
;
	logic          clk = 0, srst = 1, wr_en = 0, rd_en = 0, jabber_cnt_en, ind_wr, ind_rd;
	logic          strap_flow_ctl = 1, strap_sel_10100 = 0;
	logic [11:0]   addr = '0;
	logic [31:0]   wr_data = '0, rd_data;
	logic [15:0]   ind_rdata = 16'hbeef, ind_wdata;
	ppx_phy_stat_s phy_stat = 5'h13;
	ppx_ind_addr_s ind_addr, ind_acc_addr;
	ppx_mac_cfg_s  mac_cfg;
	int            miscompares = 0, check_count = 0, cyc = 0;

	ppx_regs ppx_regs_inst (.clk, .srst, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .phy_stat,
		.jabber_cnt_en, .strap_flow_ctl, .strap_sel_10100, .ind_addr, .ind_rdata,
		.ind_acc_addr, .ind_wdata, .ind_wr, .ind_rd, .mac_cfg);

	////////////////////////////////////////
	// Clock and a hang guard
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			miscompares++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// Bus cycles end just past the taking edge so outputs have landed
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 chk(rd_data, exp);
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	////////////////////////////////////////
	task automatic t_reset_values();
		rd(OFF_PHY_CTRL, 32'h034c);
		chk(jabber_cnt_en, 1);
		rd(OFF_IND_ADDR, 32'h001f0000);
		rd(OFF_MAC_CTRL0, 32'h78);
		chk(mac_cfg, 32'h1e);
		$display("reset values done");
	endtask

	task automatic t_phy();
		phy_stat <= 5'h04;
		wr(OFF_PHY_CTRL, 32'hffff);
		rd(OFF_PHY_CTRL, 32'hf392);
		wr(OFF_PHY_CTRL, 32'h0);
		chk(jabber_cnt_en, 0);
		rd(OFF_PHY_CTRL, 32'h0010);
		$display("phy control done");
	endtask

	task automatic t_indirect();
		wr(OFF_IND_ADDR, 32'hffe380fe);
		rd(OFF_IND_ADDR, 32'h008380fe);
		chk({ind_addr.dev, ind_addr.offset}, 32'h3fe);
		chk(ind_addr.vendor, 1);
		wr(OFF_IND_DATA, 32'h1234);
		chk({ind_wr, ind_wdata}, 32'h11234);
		chk(ind_acc_addr, 32'h0380fe);
		chk(ind_addr, 32'h0380ff);
		rd(OFF_IND_DATA, 32'hbeef);
		chk({ind_rd, ind_addr}, 32'h238100);
		wr(OFF_IND_ADDR, 32'h009fffff);
		rd(OFF_IND_DATA, 32'hbeef);
		chk(ind_addr, 32'h0);
		wr(OFF_IND_ADDR, 32'h5);
		wr(OFF_IND_DATA, 32'h1);
		chk(ind_addr, 32'h5);
		$display("indirect window done");
	endtask

	task automatic t_mac();
		wr(OFF_MAC_CTRL0, 32'hff);
		rd(OFF_MAC_CTRL0, 32'h7f);
		chk(mac_cfg, 32'h1e);
		wr(OFF_MAC_CTRL1, 32'h40);
		chk(mac_cfg, 32'h1d);
		wr(OFF_MAC_CTRL0, 32'h0);
		chk(mac_cfg, 32'h0);
		wr(OFF_MAC_CTRL1, 32'h0);
		chk(mac_cfg, 32'h2);
		rd(12'h7fc, 32'h0);
		wr(12'h7fc, 32'hffffffff);
		rd(OFF_MAC_CTRL0, 32'h0);
		$display("mac control done");
	endtask

	task automatic t_strap();
		@(posedge clk);
		srst <= 1'b1;
		strap_flow_ctl <= 1'b0;
		strap_sel_10100 <= 1'b1;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		rd(OFF_MAC_CTRL0, 32'h50);
		chk(mac_cfg, 32'h11);
		$display("strap reset done");
	endtask

	initial begin
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		t_reset_values();
		t_phy();
		t_indirect();
		t_mac();
		t_strap();
		report_and_stop();
	end

endmodule // ppx_regs_bench

`default_nettype wire
